// ==== clb_pkg.sv ====
// constants, field layouts and codes for the custom logic block
// assumes one 100 MHz clock; configuration arrives on a plain write port
// Contract
// R1: table output is truth-word bit indexed by inputs 2,1,0 (2 is msb)
// R2: four independent tables, each with three inputs and an 8-bit word
// R3: tables 0,1 feed sequencer 0; tables 2,3 feed sequencer 1
// R4: selectors 0,1 in second control register, selector 2 in third
// R5: codes 0..5 pick low, sequencer, next table, event a, event b, pin
// R6: codes 6..10 pick comparator, serial tx, spi, timer compare, timer
// R7: software uses spi signals only while that peripheral is host
// R8: software uses serial tx only in asynchronous or synchronous host mode
// R9: protected settings written only while even table enable is zero
// R10: protected: sequencer select, table controls bar enable, truth words
// R11: write setting enable may carry protected bits; clearing it may not
// R12: global enable bit switches the whole block on and off
// R13: each table has its own enable bit
// R14: unused inputs count as constant low
// R15: feedback code feeds the pair's sequencer output to both tables
// R16: input 2 can serve as the table's alternative clock
// R17: each table output goes to a pin and to the event system
// R18: output may pass a synchronizer, glitch filter or edge detector
// R19: output raises an interrupt on rising, falling or both edges
// R20: next-table source links table n to n+1, table 0 feeds table 3
// R21: sync delays two table-clock edges; filter needs >2 stable, delay 4
// R22: gated flip-flop loads even output while odd output high
// R23: jk mode holds, clears, sets or toggles, cleared on reset
// R24: selector codes 11..15 act as no input
package clb_pkg;
    localparam int NUM_TABLES = 4;
    localparam int NUM_PAIRS = 2;
    // register codes on the write port
    localparam logic [2:0] REG_FIRST = 3'h0;
    localparam logic [2:0] REG_SECOND = 3'h1;
    localparam logic [2:0] REG_THIRD = 3'h2;
    localparam logic [2:0] REG_TRUTH = 3'h3;
    localparam logic [2:0] REG_SEQ = 3'h4;
    localparam logic [2:0] REG_GLOBAL = 3'h5;
    // table_control_first fields
    localparam int EN_BIT = 0;
    localparam int CLKSRC_BIT = 1;
    localparam int FILT_LSB = 4;
    localparam int EDGE_BIT = 7;
    localparam logic [1:0] FILT_NONE = 2'h0;
    localparam logic [1:0] FILT_SYNC = 2'h1;
    localparam logic [1:0] FILT_FILTER = 2'h2;
    // selector field positions
    localparam int SEL0_LSB = 0;
    localparam int SEL1_LSB = 4;
    localparam int SEL2_LSB = 0;
    localparam int GLOBAL_EN_BIT = 0;
    localparam int SEQ_LSB = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // input selector codes
    localparam logic [3:0] SEL_MASK = 4'h0;
    localparam logic [3:0] SEL_FEEDBACK = 4'h1;
    localparam logic [3:0] SEL_LINK = 4'h2;
    localparam logic [3:0] SEL_EVENT_A = 4'h3;
    localparam logic [3:0] SEL_EVENT_B = 4'h4;
    localparam logic [3:0] SEL_PIN = 4'h5;
    localparam logic [3:0] SEL_COMP = 4'h6;
    localparam logic [3:0] SEL_SERIAL = 4'h7;
    localparam logic [3:0] SEL_SPI = 4'h8;
    localparam logic [3:0] SEL_TIMER3 = 4'h9;
    localparam logic [3:0] SEL_SIMPLE = 4'ha;
    // interrupt edge modes
    localparam logic [1:0] INT_OFF = 2'h0;
    localparam logic [1:0] INT_RISE = 2'h1;
    localparam logic [1:0] INT_FALL = 2'h2;
    localparam logic [1:0] INT_BOTH = 2'h3;
    typedef enum logic [2:0] {
        SEQ_OFF,
        SEQ_DFF,
        SEQ_JK,
        SEQ_DLATCH,
        SEQ_RS
    } clb_seq_t;
endpackage : clb_pkg

// ==== clb_out_stage.sv ====
// output stage of one table: synchronizer, glitch filter, edge pulse
// assumes tick is a one-cycle enable marking a rising table-clock edge
`timescale 1ns/1ps
module clb_out_stage
    import clb_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tick,
    input wire logic enable,
    input wire logic [1:0] filter_sel,
    input wire logic edge_en,
    input wire logic raw,
    output logic out
);
    logic [2:0] shift_ff;
    logic filt_ff;
    logic prev_ff;
    logic edge_ff;
    logic stable;
    logic level;

    // three equal samples means the input outlived two edges
    assign stable = (shift_ff[0] == shift_ff[1]) &&
        (shift_ff[1] == shift_ff[2]);
    // see R21
    assign level = (filter_sel == FILT_SYNC) ? shift_ff[1] :
                   (filter_sel == FILT_FILTER) ? filt_ff : raw;
    // see R18
    assign out = edge_en ? edge_ff : level;

    // disabled tables clear their state one cycle later
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            shift_ff <= 3'h0;
            filt_ff <= 1'b0;
            prev_ff <= 1'b0;
            edge_ff <= 1'b0;
        end
        else if (!enable)
        begin
            shift_ff <= 3'h0;
            filt_ff <= 1'b0;
            prev_ff <= 1'b0;
            edge_ff <= 1'b0;
        end
        else if (tick)
        begin
            shift_ff <= {shift_ff[1:0], raw}; // see R21
            if (stable)
            begin
                filt_ff <= shift_ff[2]; // see R21
            end
            prev_ff <= level;
            edge_ff <= level & ~prev_ff; // see R18
        end
    end
endmodule : clb_out_stage

// ==== clb_top.sv ====
// four-table glue-logic block with two pair sequencers
// assumes all inputs synchronous to clk; software keeps spi and serial
// sources in host modes and disables the block while changing clocks
`timescale 1ns/1ps
module clb_top
    import clb_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cfg_wr,
    input wire logic [1:0] cfg_table,
    input wire logic [2:0] cfg_reg,
    input wire logic [7:0] cfg_data,
    input wire logic [11:0] table_input_pins,
    input wire logic [3:0] event_line_a,
    input wire logic [3:0] event_line_b,
    input wire logic comparator_0_out,
    input wire logic serial_port0_txd,
    input wire logic serial_port1_txd,
    input wire logic spi_mosi,
    input wire logic spi_sck,
    input wire logic [2:0] compare_output,
    input wire logic [2:0] simple_timer_out,
    input wire logic [7:0] interrupt_mode,
    output logic [3:0] table_output_pin,
    output logic [3:0] table_event_out,
    output logic [3:0] irq_request,
    output logic cfg_rejected
);
    import clb_pkg::*;

    // picks one truth-table input for table n at position pos
    function automatic logic pick_source(
        input logic [3:0] sel,
        input int pos,
        input logic fb,
        input logic link,
        input logic ev_a,
        input logic ev_b,
        input logic pin,
        input logic comp,
        input logic tx0,
        input logic tx1,
        input logic mosi,
        input logic sck,
        input logic [2:0] wo,
        input logic [2:0] tmr
    );
        logic r;
        r = 1'b0;
        if (sel == SEL_FEEDBACK)
            r = fb; // see R15
        else if (sel == SEL_LINK)
            r = link; // see R20
        else if (sel == SEL_EVENT_A)
            r = ev_a; // see R5
        else if (sel == SEL_EVENT_B)
            r = ev_b; // see R5
        else if (sel == SEL_PIN)
            r = pin; // see R5
        else if (sel == SEL_COMP)
            r = comp; // see R6
        else if (sel == SEL_SERIAL)
            r = (pos == 0) ? tx0 : tx1; // see R6
        else if (sel == SEL_SPI)
            r = (pos == 2) ? sck : mosi; // see R6
        else if (sel == SEL_TIMER3)
            r = wo[pos]; // see R6
        else if (sel == SEL_SIMPLE)
            r = tmr[pos]; // see R6
        // mask and codes 11..15 stay low, see R14 and R24
        return r;
    endfunction : pick_source

    logic [7:0] first_ff [NUM_TABLES];
    logic [7:0] second_ff [NUM_TABLES];
    logic [7:0] third_ff [NUM_TABLES];
    logic [7:0] truth_ff [NUM_TABLES];
    logic [2:0] sequencer_function_select_ff [NUM_PAIRS];
    logic global_en_ff;
    logic [NUM_PAIRS-1:0] seq_ff;
    logic [NUM_TABLES-1:0] alt_prev_ff;
    logic [3:0] out_ff;
    logic [3:0] out_prev_ff;
    logic [3:0] irq_ff;
    logic rejected_ff;

    logic [1:0] even_table;
    logic locked;
    logic is_protected;
    logic [7:0] nxt_first;
    logic [3:0] table_raw;
    logic [3:0] stage_out;
    logic [3:0] table_en;
    logic [3:0] tick;
    logic [3:0] final_out;
    logic [3:0] rise;
    logic [3:0] fall;

    // protection follows the even table of the addressed pair
    assign even_table = {cfg_table[1], 1'b0}; // see R3
    assign locked = first_ff[even_table][EN_BIT]; // see R9
    assign is_protected = (cfg_reg != REG_GLOBAL); // see R10
    // enable bit always lands; other bits only while unlocked
    assign nxt_first = locked ?
        {first_ff[cfg_table][7:1], cfg_data[EN_BIT]} : cfg_data; // see R11

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < NUM_TABLES; i++)
            begin
                first_ff[i] <= CFG_RESET;
                second_ff[i] <= CFG_RESET;
                third_ff[i] <= CFG_RESET;
                truth_ff[i] <= CFG_RESET;
            end
            for (int p = 0; p < NUM_PAIRS; p++)
            begin
                sequencer_function_select_ff[p] <= 3'h0;
            end
            global_en_ff <= 1'b0;
            rejected_ff <= 1'b0;
        end
        else
        begin
            // locked first-register writes pulse too, though enable lands
            rejected_ff <= cfg_wr && locked && is_protected;
            if (cfg_wr)
            begin
                if (cfg_reg == REG_FIRST)
                    first_ff[cfg_table] <= nxt_first; // see R13
                else if (cfg_reg == REG_SECOND && !locked)
                    second_ff[cfg_table] <= cfg_data; // see R9
                else if (cfg_reg == REG_THIRD && !locked)
                    third_ff[cfg_table] <= cfg_data; // see R9
                else if (cfg_reg == REG_TRUTH && !locked)
                    truth_ff[cfg_table] <= cfg_data; // see R9
                else if (cfg_reg == REG_SEQ && !locked)
                    sequencer_function_select_ff[cfg_table[1]] <=
                        cfg_data[SEQ_LSB +: 3]; // see R9
                else if (cfg_reg == REG_GLOBAL)
                    global_en_ff <= cfg_data[GLOBAL_EN_BIT]; // see R12
            end
        end
    end

    // see R2
    for (genvar n = 0; n < NUM_TABLES; n++)
    begin : g_table
        logic [3:0] sel0;
        logic [3:0] sel1;
        logic [3:0] sel2;
        logic [2:0] in;
        logic [2:0] idx;
        logic clksrc;
        logic fb;
        logic link;

        assign sel0 = second_ff[n][SEL0_LSB +: 4]; // see R4
        assign sel1 = second_ff[n][SEL1_LSB +: 4]; // see R4
        assign sel2 = third_ff[n][SEL2_LSB +: 4]; // see R4
        assign fb = seq_ff[n / 2]; // see R15
        assign link = table_raw[(n + 1) % NUM_TABLES]; // see R20
        assign clksrc = first_ff[n][CLKSRC_BIT];
        assign in[0] = pick_source(sel0, 0, fb, link, event_line_a[n],
            event_line_b[n], table_input_pins[3*n], comparator_0_out,
            serial_port0_txd, serial_port1_txd, spi_mosi, spi_sck,
            compare_output, simple_timer_out);
        assign in[1] = pick_source(sel1, 1, fb, link, event_line_a[n],
            event_line_b[n], table_input_pins[3*n+1], comparator_0_out,
            serial_port0_txd, serial_port1_txd, spi_mosi, spi_sck,
            compare_output, simple_timer_out);
        assign in[2] = pick_source(sel2, 2, fb, link, event_line_a[n],
            event_line_b[n], table_input_pins[3*n+2], comparator_0_out,
            serial_port0_txd, serial_port1_txd, spi_mosi, spi_sck,
            compare_output, simple_timer_out);
        // input 2 as clock reads as low in the table
        assign idx = {in[2] & ~clksrc, in[1], in[0]}; // see R16
        assign table_raw[n] = truth_ff[n][idx]; // see R1
        assign table_en[n] = global_en_ff & first_ff[n][EN_BIT]; // see R13
        // the alternative clock is sampled, so it must stay well below clk
        assign tick[n] = clksrc ? (in[2] & ~alt_prev_ff[n]) : 1'b1; // see R16

        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
                alt_prev_ff[n] <= 1'b0;
            else
                alt_prev_ff[n] <= in[2];
        end

        clb_out_stage u_stage (
            .clk(clk),
            .arst_n(arst_n),
            .tick(tick[n]),
            .enable(table_en[n]),
            .filter_sel(first_ff[n][FILT_LSB +: 2]),
            .edge_en(first_ff[n][EDGE_BIT]),
            .raw(table_raw[n]),
            .out(stage_out[n])
        );
    end

    // see R3
    for (genvar p = 0; p < NUM_PAIRS; p++)
    begin : g_pair
        logic d;
        logic g;
        logic run;
        logic seq_on;
        logic nxt_seq;
        clb_seq_t mode;

        assign d = stage_out[2*p];
        assign g = stage_out[2*p+1];
        assign mode = clb_seq_t'(sequencer_function_select_ff[p]);
        assign run = table_en[2*p];
        assign seq_on = (mode != SEQ_OFF);
        // sequencer runs on the even table's clock, latches on every cycle
        always_comb
        begin
            nxt_seq = seq_ff[p];
            case (mode)
                SEQ_DFF:
                    if (tick[2*p] && g)
                        nxt_seq = d; // see R22
                SEQ_JK:
                    if (tick[2*p])
                    begin
                        case ({d, g}) // see R23
                            2'b01: nxt_seq = 1'b0;
                            2'b10: nxt_seq = 1'b1;
                            2'b11: nxt_seq = ~seq_ff[p];
                            default: nxt_seq = seq_ff[p];
                        endcase
                    end
                SEQ_DLATCH:
                    if (g)
                        nxt_seq = d;
                SEQ_RS:
                    // both set and clear high is forbidden; set wins here
                    if (d)
                        nxt_seq = 1'b1;
                    else if (g)
                        nxt_seq = 1'b0;
                default:
                    nxt_seq = 1'b0;
            endcase
        end

        // cleared on the next clock, not at once, to keep reset paths simple
        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
                seq_ff[p] <= 1'b0;
            else if (!run)
                seq_ff[p] <= 1'b0; // see R22 and R23
            else
                seq_ff[p] <= nxt_seq;
        end

        // an active sequencer drives the even table's output
        assign final_out[2*p] = seq_on ? seq_ff[p] : stage_out[2*p];
        assign final_out[2*p+1] = stage_out[2*p+1];
    end

    for (genvar n = 0; n < NUM_TABLES; n++)
    begin : g_irq
        logic [1:0] imode;
        // edges come from the pin register, so requests lag it a cycle
        assign imode = interrupt_mode[2*n +: 2];
        assign rise[n] = out_ff[n] & ~out_prev_ff[n] &
            (imode == INT_RISE || imode == INT_BOTH); // see R19
        assign fall[n] = ~out_ff[n] & out_prev_ff[n] &
            (imode == INT_FALL || imode == INT_BOTH); // see R19
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            out_ff <= 4'h0;
            out_prev_ff <= 4'h0;
            irq_ff <= 4'h0;
        end
        else
        begin
            // one mask for both enables keeps pin and event equal
            out_ff <= final_out & table_en; // see R17
            out_prev_ff <= out_ff;
            irq_ff <= rise | fall; // see R19
        end
    end

    assign table_output_pin = out_ff; // see R17
    assign table_event_out = out_ff; // see R17
    assign irq_request = irq_ff;
    assign cfg_rejected = rejected_ff;
endmodule : clb_top

// ==== clb_top_properties.sv ====
// concurrent checks on the ports of the custom logic block
// assumes one clock domain; bound into every clb_top instance
`timescale 1ns/1ps
module clb_top_properties
    import clb_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cfg_wr,
    input wire logic [1:0] cfg_table,
    input wire logic [2:0] cfg_reg,
    input wire logic [7:0] cfg_data,
    input wire logic [7:0] interrupt_mode,
    input wire logic [3:0] table_output_pin,
    input wire logic [3:0] table_event_out,
    input wire logic [3:0] irq_request,
    input wire logic cfg_rejected
);
    // enable bits are never locked, so a shadow copy follows every write
    logic [3:0] en_ff;
    logic gl_ff;
    wire logic locked = en_ff[{cfg_table[1], 1'b0}];

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            en_ff <= 4'h0;
            gl_ff <= 1'b0;
        end
        else if (cfg_wr && cfg_reg == REG_FIRST)
        begin
            en_ff[cfg_table] <= cfg_data[EN_BIT];
        end
        else if (cfg_wr && cfg_reg == REG_GLOBAL)
        begin
            gl_ff <= cfg_data[GLOBAL_EN_BIT];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    property p_event_eq;
        table_event_out == table_output_pin;
    endproperty
    a_event_eq: assert property (p_event_eq)
        else $error("event output differs from pin output");
    property p_irq_cause;
        irq_request != 4'h0 |-> (irq_request & ~($past(table_output_pin)
            ^ $past(table_output_pin, 2))) == 4'h0;
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without output edge");
    property p_irq_rise;
        irq_request[1] && interrupt_mode[3:2] == INT_RISE |->
            $past(table_output_pin[1]) && !$past(table_output_pin[1], 2);
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("rise interrupt on a non-rising edge");
    property p_irq_hit;
        $rose(table_output_pin[1]) && interrupt_mode[3:2] == INT_RISE
            |=> irq_request[1];
    endproperty
    a_irq_hit: assert property (p_irq_hit)
        else $error("rising edge raised no interrupt");
    property p_global_off;
        !gl_ff && !$past(gl_ff) && !$past(gl_ff, 2) |->
            table_output_pin == 4'h0;
    endproperty
    a_global_off: assert property (p_global_off)
        else $error("output active while block disabled");
    property p_table_off;
        (table_output_pin & ~en_ff & ~$past(en_ff) & ~$past(en_ff, 2))
            == 4'h0;
    endproperty
    a_table_off: assert property (p_table_off)
        else $error("output active while table disabled");
    property p_lock_rej;
        cfg_wr && cfg_reg != REG_GLOBAL && locked |-> ##[1:2] cfg_rejected;
    endproperty
    a_lock_rej: assert property (p_lock_rej)
        else $error("locked write not refused");
    property p_unlock_ok;
        cfg_wr && cfg_reg != REG_GLOBAL && !locked && !$past(cfg_wr)
            |=> !cfg_rejected;
    endproperty
    a_unlock_ok: assert property (p_unlock_ok)
        else $error("unlocked write refused");
    property p_rej_cause;
        cfg_rejected |-> $past(cfg_wr) || $past(cfg_wr, 2);
    endproperty
    a_rej_cause: assert property (p_rej_cause)
        else $error("refusal without a write");

    c_rej: cover property (cfg_rejected);
    c_irq: cover property (irq_request[1]);
    c_seq: cover property (table_output_pin[2] ##1 !table_output_pin[2]);
endmodule : clb_top_properties

bind clb_top clb_top_properties u_props (
    .clk(clk),
    .arst_n(arst_n),
    .cfg_wr(cfg_wr),
    .cfg_table(cfg_table),
    .cfg_reg(cfg_reg),
    .cfg_data(cfg_data),
    .interrupt_mode(interrupt_mode),
    .table_output_pin(table_output_pin),
    .table_event_out(table_event_out),
    .irq_request(irq_request),
    .cfg_rejected(cfg_rejected)
);

// ==== clb_src_model.sv ====
// peripheral and event sources around the block
// assumes the bench sets one level that all sources follow
`timescale 1ns/1ps
module clb_src_model (
    input wire logic level,
    output logic comparator_0_out,
    output logic serial_port0_txd,
    output logic serial_port1_txd,
    output logic spi_mosi,
    output logic spi_sck,
    output logic [2:0] compare_output,
    output logic [2:0] simple_timer_out,
    output logic [3:0] event_line_a,
    output logic [3:0] event_line_b
);
    // serial ports and spi act as hosts, so their lines always carry data
    assign {serial_port0_txd, serial_port1_txd} = {2{level}};
    assign {spi_mosi, spi_sck} = {2{level}};
    assign comparator_0_out = level;
    assign compare_output = {3{level}};
    assign simple_timer_out = {3{level}};
    assign event_line_a = {4{level}};
    assign event_line_b = {4{level}};
endmodule : clb_src_model

// ==== tb_clb_top.sv ====
// self-checking bench for the custom logic block
// assumes the source model drives every peripheral line from one level
`timescale 1ns/1ps
module tb_clb_top;
    import clb_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cfg_wr = 1'b0;
    logic [1:0] cfg_table = 2'h0;
    logic [2:0] cfg_reg = 3'h0;
    logic [7:0] cfg_data = 8'h00;
    logic [11:0] pins = 12'h000;
    logic level = 1'b0;
    logic [7:0] interrupt_mode = 8'h34;
    logic [7:0] word = 8'h42;
    logic [4:0] jk_j = 5'h0b;
    logic [4:0] jk_k = 5'h1a;
    logic [4:0] jk_q = 5'h09;
    wire logic comp, tx0, tx1, mosi, sck, cfg_rejected;
    wire logic [2:0] wo, tmr;
    wire logic [3:0] ev_a, ev_b, outp, evo, irq;
    int errors = 0;
    int checks_done = 0;
    int rej_cnt = 0;
    int irq1_cnt = 0;
    int irq2_cnt = 0;
    int n;
    int i;

    always #5 clk = ~clk;
    always @(negedge clk) if (cfg_rejected === 1'b1) rej_cnt++;
    always @(negedge clk) if (irq[1] === 1'b1) irq1_cnt++;
    always @(negedge clk) if (irq[2] === 1'b1) irq2_cnt++;

    clb_src_model u_src (.level(level), .comparator_0_out(comp),
        .serial_port0_txd(tx0), .serial_port1_txd(tx1), .spi_mosi(mosi),
        .spi_sck(sck), .compare_output(wo), .simple_timer_out(tmr),
        .event_line_a(ev_a), .event_line_b(ev_b));
    clb_top dut (.clk(clk), .arst_n(arst_n), .cfg_wr(cfg_wr),
        .cfg_table(cfg_table), .cfg_reg(cfg_reg), .cfg_data(cfg_data),
        .table_input_pins(pins), .event_line_a(ev_a), .event_line_b(ev_b),
        .comparator_0_out(comp), .serial_port0_txd(tx0),
        .serial_port1_txd(tx1), .spi_mosi(mosi), .spi_sck(sck),
        .compare_output(wo), .simple_timer_out(tmr),
        .interrupt_mode(interrupt_mode), .table_output_pin(outp),
        .table_event_out(evo), .irq_request(irq),
        .cfg_rejected(cfg_rejected));

    task automatic chk(input string name, input logic [7:0] seen,
        input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // the gap cycle keeps cfg_wr from being raised twice in one step
    task automatic wr(input logic [1:0] t, input logic [2:0] r,
        input logic [7:0] d);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_table = t;
        cfg_reg = r;
        cfg_data = d;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask : wr

    task automatic idle(input int c);
        repeat (c) @(negedge clk);
    endtask : idle

    task automatic close_out;
        if (errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out

    initial
    begin
        idle(3);
        arst_n = 1'b1;
        chk("reset outputs", {outp, irq}, 8'h00);
        wr(2'h0, REG_GLOBAL, 8'h01);
        wr(2'h1, REG_TRUTH, word);
        wr(2'h1, REG_SECOND, 8'h55);
        wr(2'h1, REG_THIRD, 8'h05);
        wr(2'h1, REG_FIRST, 8'h01);
        for (i = 0; i < 8; i++)
        begin
            pins[5:3] = i[2:0];
            idle(2);
            chk("truth index", {7'h0, outp[1]}, {7'h0, word[i]});
        end
        chk("rise interrupts", 8'(irq1_cnt), 8'h02);
        wr(2'h1, REG_TRUTH, 8'hff);
        wr(2'h0, REG_TRUTH, 8'haa);
        pins = 12'hfff;
        level = 1'b1;
        for (i = 0; i < 16; i++)
        begin
            // feedback is skipped here, and no later scenario selects it either
            if (i != 1)
            begin
                wr(2'h0, REG_FIRST, 8'h00);
                wr(2'h0, REG_SECOND, {4'h0, i[3:0]});
                wr(2'h0, REG_FIRST, 8'h01);
                idle(2);
                chk("source code", {7'h0, outp[0]},
                    {7'h0, i > 1 && i < 11});
            end
        end
        wr(2'h0, REG_FIRST, 8'h00);
        wr(2'h0, REG_SECOND, {4'h0, SEL_PIN});
        wr(2'h0, REG_FIRST, 8'h01);
        n = rej_cnt;
        wr(2'h1, REG_TRUTH, 8'h00);
        wr(2'h0, REG_TRUTH, 8'h55);
        idle(2);
        chk("refusals", 8'(rej_cnt - n), 8'h02);
        chk("locked outputs", {6'h0, outp[1:0]}, 8'h03);
        chk("event lines", {6'h0, evo[1:0]}, 8'h03);
        wr(2'h3, REG_TRUTH, 8'haa);
        wr(2'h3, REG_SECOND, {4'h0, SEL_LINK});
        wr(2'h3, REG_FIRST, 8'h01);
        idle(2);
        chk("link wrap", {7'h0, outp[3]}, 8'h01);
        pins = 12'h000;
        wr(2'h3, REG_SECOND, {4'h0, SEL_PIN});
        wr(2'h2, REG_TRUTH, 8'haa);
        wr(2'h2, REG_SECOND, {4'h0, SEL_PIN});
        wr(2'h2, REG_SEQ, 8'(SEQ_JK));
        wr(2'h2, REG_FIRST, 8'h01);
        for (i = 0; i < 5; i++)
        begin
            pins[6] = jk_j[i];
            pins[9] = jk_k[i];
            @(negedge clk);
            pins[6] = 1'b0;
            pins[9] = 1'b0;
            idle(2);
            chk("jk sequencer", {7'h0, outp[2]}, {7'h0, jk_q[i]});
        end
        wr(2'h2, REG_FIRST, 8'h00);
        wr(2'h3, REG_FIRST, {2'h0, FILT_SYNC, 4'h1});
        pins[9] = 1'b1;
        idle(2);
        chk("sync delay", {7'h0, outp[3]}, 8'h00);
        idle(1);
        chk("sync delay", {7'h0, outp[3]}, 8'h01);
        chk("both-edge interrupts", 8'(irq2_cnt), 8'h04);
        wr(2'h0, REG_GLOBAL, 8'h00);
        idle(2);
        chk("global off", {4'h0, outp}, 8'h00);
        close_out();
    end
endmodule : tb_clb_top
